// ### inc/rss_pkg.sv
// Package with timing counts, state codes and field positions for the reset source sequencer.
package rss_pkg;
	localparam int unsigned CLK_MHZ = 250;
	// Times in their own units, then cycle counts derived from the clock rate.
	localparam int unsigned POR_TIME_US = 21000;
	localparam int unsigned PIN_TIME_US = 760;
	localparam int unsigned DIG_TIME_US = 760;
	localparam int unsigned BYTE_TIME_US = 91;
	localparam int unsigned PHY_HOLD_US = 102;
	localparam int unsigned VPHY_HOLD_US = 1;
	localparam int unsigned HMAC_HOLD_US = 1;
	localparam int unsigned IF_RESET_US = 1;
	localparam int unsigned POR_CYCLES = POR_TIME_US * CLK_MHZ;
	localparam int unsigned PIN_CYCLES = PIN_TIME_US * CLK_MHZ;
	localparam int unsigned DIG_CYCLES = DIG_TIME_US * CLK_MHZ;
	localparam int unsigned BYTE_CYCLES = BYTE_TIME_US * CLK_MHZ;
	localparam int unsigned PHY_CYCLES = PHY_HOLD_US * CLK_MHZ;
	localparam int unsigned VPHY_CYCLES = VPHY_HOLD_US * CLK_MHZ;
	localparam int unsigned HMAC_CYCLES = HMAC_HOLD_US * CLK_MHZ;
	localparam int unsigned IF_CYCLES = IF_RESET_US * CLK_MHZ;
	localparam int unsigned CNT_W = 24;
	localparam int unsigned EE_BYTES_W = 16;
	localparam int unsigned STRAP_W = 8;
	// Field positions of the reset control register image.
	localparam int unsigned RC_DIGITAL = 0;
	localparam int unsigned RC_PHY_A = 1;
	localparam int unsigned RC_PHY_B = 2;
	localparam int unsigned RC_VPHY = 3;
	localparam int unsigned RC_HMAC = 5;
	localparam logic [31:0] RESET_CONTROL_REG_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		RSS_CHIP = 3'b000,
		RSS_IFRST = 3'b001,
		RSS_EELOAD = 3'b010,
		RSS_READY = 3'b011
	} rss_state_t;
endpackage : rss_pkg

// ### verilog/rss_timer.sv
// Self-clearing reset timer for one single-module reset.
`timescale 1ns/1ps
`default_nettype none
module rss_timer #(
	parameter int unsigned HOLD = 1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic start,
	output logic busy
);
	import rss_pkg::*;

	typedef struct packed {
		logic busy;
		logic [CNT_W-1:0] cnt;
	} rss_tmr_t;

	rss_tmr_t st;
	rss_tmr_t next_st;

	always_comb begin
		next_st = st;
		if (clr) begin
			next_st = '0;
		end else if (!st.busy) begin
			// A start while busy is ignored, so the hold time cannot be stretched.
			if (start) begin
				next_st.busy = 1'b1;
				next_st.cnt = CNT_W'(HOLD - 1);
			end
		end else if (st.cnt == '0) begin
			next_st.busy = 1'b0;
		end else begin
			next_st.cnt = st.cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign busy = st.busy;
endmodule : rss_timer
`default_nettype wire

// ### verilog/rss_sequencer.sv
// Reset source sequencer: chip, digital and single-module resets with ready signalling.
//
// Overview of operation
// - Power-on resets everything, latches straps, tunes pads, releases chip reset, then loads EEPROM.
// - Power-on sequence lasts about 21 ms plus 91 us per EEPROM byte.
// - External reset pin low starts chip reset; host holds it low long enough.
// - Pin reset sequence lasts about 760 us plus 91 us per EEPROM byte.
// - Digital soft reset resets all sub-modules except PHYs and the virtual PHY, then loads EEPROM.
// - Digital reset keeps latched straps; soft straps revert and strap defaults reload.
// - Digital reset leaves soft-reset-immune bits unchanged.
// - Digital reset lasts about 760 us plus 91 us per EEPROM byte.
// - Byte-order probe reads invalid until host-interface resets finish.
// - Ready bit set in both config registers when reset completes.
// - Single-module resets touch one module; no strap latch, no EEPROM load.
// - Port A PHY reset bit or soft bit resets only PHY A; clears after 102 us.
// - Port B PHY reset bit or soft bit resets only PHY B; clears after 102 us.
// - PHY soft-bit reset preserves that PHY's soft-reset-immune bits.
// - PHY resets itself on leaving power-down without touching its registers.
// - Virtual PHY reset bit or control bit resets only virtual PHY; clears after 1 us.
// - Host MAC reset resets MAC logic and reloads MAC address from EEPROM.
// - Host MAC reset sets EEPROM busy, clears config-loaded; bit self-clears.
// - Host MAC reset keeps its interrupt status and config register bits.
// - Switch fabric reset resets fabric, not interface logic; host clears the bit.
// - Writes to a set self-clearing reset bit are ignored, except in the cycle after its timer ends, while the bit still reads one.
// - A PHY reset is held at least 102 us.
// - Digital reset aborts any EEPROM command in progress.
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer #(
	parameter int unsigned POR_CNT = rss_pkg::POR_CYCLES,
	parameter int unsigned PIN_CNT = rss_pkg::PIN_CYCLES,
	parameter int unsigned DIG_CNT = rss_pkg::DIG_CYCLES,
	parameter int unsigned BYTE_CNT = rss_pkg::BYTE_CYCLES,
	parameter int unsigned PHY_CNT = rss_pkg::PHY_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ext_reset_n,
	input wire logic [rss_pkg::STRAP_W-1:0] strap_pins,
	input wire logic [rss_pkg::EE_BYTES_W-1:0] eeprom_byte_count,
	input wire logic eeprom_cmd_active,
	input wire logic digital_reset_wr,
	input wire logic port_a_phy_reset_bit_wr,
	input wire logic port_b_phy_reset_bit_wr,
	input wire logic virtual_phy_reset_bit_wr,
	input wire logic host_mac_reset_bit_wr,
	input wire logic phy_a_soft_reset_wr,
	input wire logic phy_b_soft_reset_wr,
	input wire logic virtual_phy_ctrl_reset_wr,
	input wire logic phy_a_powerdown_exit,
	input wire logic phy_b_powerdown_exit,
	input wire logic switch_fabric_reset_bit,
	output logic [31:0] reset_control_reg,
	output logic device_ready,
	output logic byte_order_valid,
	output logic [rss_pkg::STRAP_W-1:0] latched_straps,
	output logic soft_strap_restore,
	output logic pad_tune_n,
	output logic outputs_enable,
	output logic chip_reset_n,
	output logic digital_reset_n,
	output logic soft_reset_immune_keep,
	output logic eeprom_load_start,
	output logic eeprom_abort,
	output logic eeprom_loading,
	output logic phy_a_reset_n,
	output logic phy_b_reset_n,
	output logic phy_a_regs_keep,
	output logic phy_b_regs_keep,
	output logic phy_a_immune_keep,
	output logic phy_b_immune_keep,
	output logic virtual_phy_reset_n,
	output logic host_mac_reset_n,
	output logic host_mac_addr_reload,
	output logic eeprom_busy_flag,
	output logic eeprom_cfg_loaded,
	output logic host_mac_status_keep,
	output logic fabric_reset_n,
	output logic fabric_if_reset_n
);
	import rss_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		rss_state_t state;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] pcnt;
		logic [EE_BYTES_W-1:0] bytes;
		logic is_digital;
		logic por_done;
		logic [STRAP_W-1:0] straps;
		logic ready;
		logic if_ok;
		logic pad_n;
		logic out_en;
		logic chip_n;
		logic dig_n;
		logic load_go;
		logic abort;
		logic hmac_go;
		logic hmac_n;
		logic ee_busy;
		logic ee_loaded;
		logic restore;
		logic pa_keep;
		logic pb_keep;
		logic pa_imm;
		logic pb_imm;
		logic pa_n;
		logic pb_n;
		logic vp_n;
		logic sw_n;
		logic loading;
		logic hm_keep;
		logic [31:0] rc;
	} rss_seq_t;

	rss_seq_t st;
	rss_seq_t next_st;
	logic pa_busy;
	logic pb_busy;
	logic vp_busy;
	logic hm_busy;
	logic single_ok;

	function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
		cyc = CNT_W'(n - 1);
	endfunction : cyc

	// Single-module resets are accepted only while ready is set and no timer for that bit runs.
	assign single_ok = st.ready;

	// ==========================================================
	// Single-module reset timers
	// ==========================================================
	rss_timer #(.HOLD(PHY_CNT)) u_phy_a (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clr(st.state == RSS_CHIP),
		.start(single_ok && (port_a_phy_reset_bit_wr || phy_a_soft_reset_wr || phy_a_powerdown_exit)),
		.busy(pa_busy)
	);
	rss_timer #(.HOLD(PHY_CNT)) u_phy_b (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clr(st.state == RSS_CHIP),
		.start(single_ok && (port_b_phy_reset_bit_wr || phy_b_soft_reset_wr || phy_b_powerdown_exit)),
		.busy(pb_busy)
	);
	rss_timer #(.HOLD(VPHY_CYCLES)) u_vphy (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clr(st.state == RSS_CHIP),
		.start(single_ok && (virtual_phy_reset_bit_wr || virtual_phy_ctrl_reset_wr)),
		.busy(vp_busy)
	);
	rss_timer #(.HOLD(HMAC_CYCLES)) u_hmac (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clr(st.state == RSS_CHIP || !st.dig_n),
		.start(single_ok && host_mac_reset_bit_wr),
		.busy(hm_busy)
	);

	// ==========================================================
	// Sequencer
	// ==========================================================
	always_comb begin
		next_st = st;
		next_st.load_go = 1'b0;
		next_st.abort = 1'b0;
		next_st.restore = 1'b0;
		next_st.hmac_go = 1'b0;
		unique case (st.state)
			RSS_CHIP: begin
				// Straps follow the pins while the reset pin is low, and close when it is first seen high.
				next_st.straps = strap_pins;
				next_st.ready = 1'b0;
				next_st.if_ok = 1'b0;
				next_st.chip_n = 1'b0;
				next_st.dig_n = 1'b0;
				next_st.out_en = 1'b0;
				next_st.pad_n = 1'b1;
				if (ext_reset_n) begin
					next_st.pad_n = 1'b0;
					next_st.pcnt = cyc(IF_CYCLES);
					next_st.state = RSS_IFRST;
					next_st.is_digital = 1'b0;
					next_st.cnt = st.por_done ? cyc(PIN_CNT) : cyc(POR_CNT);
					next_st.por_done = 1'b1;
				end
			end
			RSS_IFRST: begin
				// The tune pulse has its own count and lasts one microsecond, or ends with the interval if that is shorter.
				if (!st.pad_n) begin
					if (st.pcnt == '0 || st.cnt == '0) begin
						next_st.pad_n = 1'b1;
					end else begin
						next_st.pcnt = st.pcnt - 1'b1;
					end
				end
				if (st.cnt == '0) begin
					next_st.out_en = 1'b1;
					next_st.chip_n = 1'b1;
					next_st.dig_n = 1'b1;
					next_st.if_ok = 1'b1;
					next_st.state = RSS_EELOAD;
					next_st.load_go = 1'b1;
					next_st.bytes = eeprom_byte_count;
					next_st.cnt = cyc(BYTE_CNT);
					next_st.ee_busy = 1'b1;
					next_st.ee_loaded = 1'b0;
				end else begin
					next_st.cnt = st.cnt - 1'b1;
				end
			end
			RSS_EELOAD: begin
				if (st.bytes == '0) begin
					next_st.state = RSS_READY;
					next_st.ready = 1'b1;
					next_st.ee_busy = 1'b0;
					next_st.ee_loaded = 1'b1;
					next_st.rc[RC_DIGITAL] = 1'b0;
				end else if (st.cnt == '0) begin
					next_st.bytes = st.bytes - 1'b1;
					next_st.cnt = cyc(BYTE_CNT);
				end else begin
					next_st.cnt = st.cnt - 1'b1;
				end
			end
			RSS_READY: begin
				if (digital_reset_wr) begin
					next_st.state = RSS_IFRST;
					next_st.is_digital = 1'b1;
					next_st.ready = 1'b0;
					next_st.if_ok = 1'b0;
					next_st.dig_n = 1'b0;
					next_st.abort = eeprom_cmd_active;
					next_st.restore = 1'b1;
					next_st.cnt = cyc(DIG_CNT);
					next_st.rc[RC_DIGITAL] = 1'b1;
				end
			end
			default: begin
				next_st.state = RSS_CHIP;
			end
		endcase
		// Ready falls with the first low sample, so a host never sees a stale ready while the pin is held.
		if (!ext_reset_n) begin
			next_st.state = RSS_CHIP;
			next_st.ready = 1'b0;
			next_st.if_ok = 1'b0;
		end
		// Host MAC reset reloads the address through the loader and flags it busy meanwhile.
		if (single_ok && host_mac_reset_bit_wr && !st.rc[RC_HMAC] && !st.hmac_go) begin
			next_st.hmac_go = 1'b1;
		end
		if (hm_busy || st.hmac_go) begin
			next_st.ee_busy = 1'b1;
			next_st.ee_loaded = 1'b0;
		end else if (st.rc[RC_HMAC] && st.state == RSS_READY) begin
			next_st.ee_busy = 1'b0;
			next_st.ee_loaded = 1'b1;
		end
		next_st.hmac_n = !(hm_busy || st.hmac_go) && next_st.dig_n;
		// Each self-clearing bit mirrors its timer, so it reads one for the whole hold.
		next_st.rc[RC_PHY_A] = pa_busy;
		next_st.rc[RC_PHY_B] = pb_busy;
		next_st.rc[RC_VPHY] = vp_busy;
		next_st.rc[RC_HMAC] = hm_busy || st.hmac_go;
		// The digital reset never reaches the PHYs or the virtual PHY.
		next_st.pa_n = !pa_busy && next_st.chip_n;
		next_st.pb_n = !pb_busy && next_st.chip_n;
		next_st.vp_n = !vp_busy && next_st.chip_n;
		next_st.pa_keep = phy_a_powerdown_exit || (st.pa_keep && pa_busy);
		next_st.pb_keep = phy_b_powerdown_exit || (st.pb_keep && pb_busy);
		next_st.pa_imm = phy_a_soft_reset_wr || (st.pa_imm && pa_busy);
		next_st.pb_imm = phy_b_soft_reset_wr || (st.pb_imm && pb_busy);
		next_st.sw_n = !switch_fabric_reset_bit && next_st.dig_n;
		next_st.loading = next_st.state == RSS_EELOAD;
		next_st.hm_keep = !next_st.hmac_n && next_st.dig_n;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st <= '0;
			st.state <= RSS_CHIP;
			st.pad_n <= 1'b1;
			st.rc <= RESET_CONTROL_REG_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign reset_control_reg = st.rc;
	assign device_ready = st.ready;
	assign byte_order_valid = st.if_ok;
	assign latched_straps = st.straps;
	assign soft_strap_restore = st.restore;
	assign pad_tune_n = st.pad_n;
	assign outputs_enable = st.out_en;
	assign chip_reset_n = st.chip_n;
	assign digital_reset_n = st.dig_n;
	assign soft_reset_immune_keep = st.is_digital;
	assign eeprom_load_start = st.load_go;
	assign eeprom_abort = st.abort;
	assign eeprom_loading = st.loading;
	assign phy_a_reset_n = st.pa_n;
	assign phy_b_reset_n = st.pb_n;
	assign phy_a_regs_keep = st.pa_keep;
	assign phy_b_regs_keep = st.pb_keep;
	assign phy_a_immune_keep = st.pa_imm;
	assign phy_b_immune_keep = st.pb_imm;
	assign virtual_phy_reset_n = st.vp_n;
	assign host_mac_reset_n = st.hmac_n;
	assign host_mac_addr_reload = st.hmac_go;
	assign eeprom_busy_flag = st.ee_busy;
	assign eeprom_cfg_loaded = st.ee_loaded;
	assign host_mac_status_keep = st.hm_keep;
	assign fabric_reset_n = st.sw_n;
	assign fabric_if_reset_n = st.dig_n;
endmodule : rss_sequencer
`default_nettype wire

// ### dv/rss_sequencer_assertions.sv
// Concurrent checks on the reset source sequencer ports.
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer_assertions #(
	parameter int unsigned PHY_CNT = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ext_reset_n,
	input wire logic digital_reset_wr,
	input wire logic switch_fabric_reset_bit,
	input wire logic [31:0] reset_control_reg,
	input wire logic device_ready,
	input wire logic [rss_pkg::STRAP_W-1:0] latched_straps,
	input wire logic pad_tune_n,
	input wire logic digital_reset_n,
	input wire logic phy_a_reset_n,
	input wire logic eeprom_busy_flag,
	input wire logic fabric_reset_n,
	input wire logic fabric_if_reset_n
);
	import rss_pkg::*;
	localparam int PHY_MAX = PHY_CNT + 4;
	logic [31:0] pa_run;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Counts how long the port A bit has stood, so the long hold needs no long delay range.
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !reset_control_reg[RC_PHY_A]) begin
			pa_run <= '0;
		end else begin
			pa_run <= pa_run + 32'h1;
		end
	end
	// ====================
	// Self-clearing bits and their targets.
	a_phy_held: assert property ($rose(reset_control_reg[RC_PHY_A]) |-> reset_control_reg[RC_PHY_A] [*6])
		else $error("phy a bit dropped early");
	a_phy_clear: assert property (pa_run <= 32'(PHY_MAX))
		else $error("phy a bit never cleared");
	a_phy_min: assert property ($fell(reset_control_reg[RC_PHY_A]) |-> pa_run >= 32'(PHY_CNT))
		else $error("phy a bit cleared before the hold time");
	a_phy_in_rst: assert property (reset_control_reg[RC_PHY_A] |-> !phy_a_reset_n)
		else $error("phy a bit set but phy not in reset");
	a_hmac_busy: assert property (reset_control_reg[RC_HMAC] |-> eeprom_busy_flag)
		else $error("eeprom busy low during host mac reset");
	// ====================
	// Chip, digital and switch fabric resets.
	a_pad_ready: assert property (!pad_tune_n |-> !device_ready)
		else $error("ready during pad tuning");
	a_pin_chip: assert property (!ext_reset_n ##1 !ext_reset_n |-> !device_ready)
		else $error("ready while reset pin held low");
	a_dig_start: assert property (digital_reset_wr && device_ready |-> ##[1:3] !digital_reset_n)
		else $error("digital reset not started");
	a_dig_phys: assert property (reset_control_reg[RC_DIGITAL] |-> phy_a_reset_n)
		else $error("phy reset by digital reset");
	a_dig_straps: assert property (reset_control_reg[RC_DIGITAL] |=> $stable(latched_straps))
		else $error("straps relatched by digital reset");
	a_fabric_rst: assert property ((switch_fabric_reset_bit && device_ready) [*3] |-> !fabric_reset_n && fabric_if_reset_n)
		else $error("fabric reset wrong");
endmodule : rss_sequencer_assertions

bind rss_sequencer rss_sequencer_assertions #(.PHY_CNT(PHY_CNT)) chk_u (
	.sys_clk, .rst_n, .ext_reset_n, .digital_reset_wr, .switch_fabric_reset_bit, .reset_control_reg,
	.device_ready, .latched_straps, .pad_tune_n, .digital_reset_n, .phy_a_reset_n, .eeprom_busy_flag,
	.fabric_reset_n, .fabric_if_reset_n
);
`default_nettype wire

// ### dv/rss_host_model.sv
// Host controller model that drives the external reset pin and waits for ready.
`timescale 1ns/1ps
`default_nettype none
module rss_host_model #(
	parameter int LOW_CYCLES = 6
) (
	input wire logic sys_clk,
	input wire logic pin_req,
	input wire logic device_ready,
	output logic ext_reset_n,
	output logic busy
);
	int cnt;
	// ====================
	// Reset pin driver.
	initial begin
		ext_reset_n = 1'b1;
		busy = 1'b0;
		cnt = 0;
	end
	// The host stays busy, touching nothing, until ready is seen again.
	always @(posedge sys_clk) begin
		if (pin_req && !busy) begin
			ext_reset_n <= 1'b0;
			busy <= 1'b1;
			cnt <= 0;
		end else if (busy && !ext_reset_n) begin
			cnt <= cnt + 1;
			if (cnt == LOW_CYCLES - 1) ext_reset_n <= 1'b1;
		end else if (busy && device_ready) begin
			busy <= 1'b0;
		end
	end
endmodule : rss_host_model
`default_nettype wire

// ### dv/rss_sequencer_test.sv
// Self-checking testbench for the reset source sequencer.
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer_test;
	import rss_pkg::*;
	localparam int POR = 40;
	localparam int DIG = 20;
	localparam int BYT = 4;
	localparam int PHY = 8;
	logic sys_clk, rst_n, pin_req, host_busy, ext_reset_n, eeprom_cmd_active, fab, mon_off;
	logic [7:0] strap_pins, latched_straps, wr, s;
	logic [1:0] pde;
	logic [15:0] eeprom_byte_count;
	logic [31:0] reset_control_reg, rc_prev;
	logic device_ready, byte_order_valid, soft_strap_restore, eeprom_abort, phy_a_regs_keep, phy_a_immune_keep;
	logic pad_tune_n, outputs_enable, chip_reset_n, soft_reset_immune_keep, eeprom_busy_flag, eeprom_cfg_loaded;
	logic host_mac_status_keep, host_mac_addr_reload, phy_b_regs_keep, phy_b_immune_keep;
	logic phy_a_reset_n, phy_b_reset_n, virtual_phy_reset_n, host_mac_reset_n, fabric_reset_n, fabric_if_reset_n;
	int mismatches, num_checks, seed, i, n, b, ab_cnt, sr_cnt, hr_cnt, a0, s0;
	int bitn[7] = '{1, 2, 3, 5, 1, 2, 3};
	int hld[7] = '{PHY, PHY, 250, 250, PHY, PHY, 250};
	int tgt[7] = '{0, 1, 2, 3, 0, 1, 2};
	logic [31:0] exp_q[$];

	rss_sequencer #(.POR_CNT(POR), .PIN_CNT(20), .DIG_CNT(DIG), .BYTE_CNT(BYT), .PHY_CNT(PHY)) dut_u (
		.sys_clk, .rst_n, .ext_reset_n, .strap_pins, .eeprom_byte_count, .eeprom_cmd_active,
		.digital_reset_wr(wr[7]), .port_a_phy_reset_bit_wr(wr[0]), .port_b_phy_reset_bit_wr(wr[1]),
		.virtual_phy_reset_bit_wr(wr[2]), .host_mac_reset_bit_wr(wr[3]), .phy_a_soft_reset_wr(wr[4]),
		.phy_b_soft_reset_wr(wr[5]), .virtual_phy_ctrl_reset_wr(wr[6]), .phy_a_powerdown_exit(pde[0]),
		.phy_b_powerdown_exit(pde[1]), .switch_fabric_reset_bit(fab), .reset_control_reg, .device_ready,
		.byte_order_valid, .latched_straps, .soft_strap_restore, .pad_tune_n, .outputs_enable,
		.chip_reset_n, .digital_reset_n(), .soft_reset_immune_keep, .eeprom_load_start(),
		.eeprom_abort, .eeprom_loading(), .phy_a_reset_n, .phy_b_reset_n, .phy_a_regs_keep,
		.phy_b_regs_keep, .phy_a_immune_keep, .phy_b_immune_keep, .virtual_phy_reset_n,
		.host_mac_reset_n, .host_mac_addr_reload, .eeprom_busy_flag, .eeprom_cfg_loaded,
		.host_mac_status_keep, .fabric_reset_n, .fabric_if_reset_n
	);
	rss_host_model host_u (.sys_clk, .pin_req, .device_ready, .ext_reset_n, .busy(host_busy));

	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task end_sim;
		if (mismatches == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim
	task automatic pulse(int k);
		wr[k] <= 1'b1;
		@(posedge sys_clk);
		wr[k] <= 1'b0;
		@(posedge sys_clk);
	endtask : pulse
	task automatic drop;
		int m;
		m = 0;
		while (device_ready !== 1'b0 && m < 8) begin
			@(posedge sys_clk);
			m++;
		end
	endtask : drop
	task automatic rise(output int m);
		m = 0;
		while (device_ready !== 1'b1 && m < 3000) begin
			@(posedge sys_clk);
			m++;
		end
	endtask : rise

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// ====================
	// Monitor: every change of the reset control image, except while mon_off is set, must match the next note.
	always @(posedge sys_clk) begin
		rc_prev <= reset_control_reg;
		ab_cnt <= ab_cnt + int'(eeprom_abort === 1'b1);
		sr_cnt <= sr_cnt + int'(soft_strap_restore === 1'b1);
		hr_cnt <= hr_cnt + int'(host_mac_addr_reload === 1'b1);
		if (rst_n && !mon_off && reset_control_reg !== rc_prev) begin
			if (exp_q.size() == 0) chk("rc_extra", reset_control_reg, rc_prev);
			else chk("rc", reset_control_reg, exp_q.pop_front());
		end
	end
	initial begin
		#80000;
		mismatches++;
		end_sim();
	end
	// ====================
	// Main sequence.
	initial begin
		seed = 32'h63c7;
		{rst_n, pin_req, eeprom_cmd_active, fab, mon_off, wr, pde} = '0;
		{mismatches, num_checks, ab_cnt, sr_cnt, hr_cnt} = '0;
		strap_pins = 8'h5a;
		eeprom_byte_count = 16'h0002;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		rise(n);
		chk("por_len", n >= POR + 2 * BYT && n <= POR + 2 * BYT + 4, 1);
		chk("por_up", {pad_tune_n, outputs_enable, chip_reset_n, eeprom_busy_flag, eeprom_cfg_loaded}, 5'b11101);
		chk("por_straps", latched_straps, 8'h5a);
		chk("probe", byte_order_valid, 1);
		chk("rc_reset", reset_control_reg, 32'h0);
		for (i = 0; i < 7; i++) begin
			exp_q.push_back(32'h1 << bitn[i]);
			exp_q.push_back(32'h0);
			pulse(i);
			n = 0;
			while (reset_control_reg[bitn[i]] !== 1'b1 && n < 10) begin
				@(posedge sys_clk);
				n++;
			end
			pulse(i);
			chk("isolate", {host_mac_reset_n, virtual_phy_reset_n, phy_b_reset_n, phy_a_reset_n}, 4'hf & ~(4'h1 << tgt[i]));
			if (i == 4) chk("immune", phy_a_immune_keep, 1);
			if (i == 5) chk("immune_b", phy_b_immune_keep, 1);
			if (i == 3) chk("hmac_flags", {eeprom_busy_flag, eeprom_cfg_loaded, host_mac_status_keep}, 3'b101);
			n = 2;
			while (reset_control_reg[bitn[i]] !== 1'b0 && n < 600) begin
				@(posedge sys_clk);
				n++;
			end
			chk("hold", n >= hld[i] - 2 && n <= hld[i] + 2, 1);
		end
		chk("reload", hr_cnt, 1);
		chk("hmac_done", {eeprom_busy_flag, eeprom_cfg_loaded}, 2'b01);
		mon_off <= 1'b1;
		pde <= 2'b11;
		@(posedge sys_clk);
		pde <= 2'b00;
		repeat (3) @(posedge sys_clk);
		chk("pd_reset", {phy_a_reset_n, phy_a_regs_keep, phy_b_reset_n, phy_b_regs_keep}, 4'b0101);
		repeat (30) @(posedge sys_clk);
		mon_off <= 1'b0;
		s = latched_straps;
		b = $random(seed) & 3;
		strap_pins <= ~s;
		eeprom_byte_count <= 16'(b);
		eeprom_cmd_active <= 1'b1;
		a0 = ab_cnt;
		s0 = sr_cnt;
		exp_q.push_back(32'h1);
		exp_q.push_back(32'h0);
		pulse(7);
		drop();
		pulse(0);
		rise(n);
		chk("dig_len", n + 3 >= DIG + b * BYT && n + 3 <= DIG + b * BYT + 4, 1);
		chk("dig_keep", soft_reset_immune_keep, 1);
		chk("dig_straps", latched_straps, s);
		chk("abort", ab_cnt - a0, 1);
		chk("restore", sr_cnt - s0, 1);
		eeprom_cmd_active <= 1'b0;
		s = 8'($random(seed));
		strap_pins <= s;
		pin_req <= 1'b1;
		@(posedge sys_clk);
		pin_req <= 1'b0;
		drop();
		rise(n);
		chk("pin_len", n >= 20 + b * BYT, 1);
		chk("pin_straps", latched_straps, s);
		chk("pin_keep", soft_reset_immune_keep, 0);
		fab <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("fabric", {fabric_reset_n, fabric_if_reset_n}, 2'b01);
		chk("host_idle", host_busy, 0);
		fab <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("fabric_off", {fabric_reset_n, fabric_if_reset_n}, 2'b11);
		end_sim();
	end
endmodule : rss_sequencer_test
`default_nettype wire
